// >>> src/parallel_drive_start_port.sv
// Parallel control port: qualifies contact inputs, issues motion commands,
// drives open-collector status outputs.
// Assumes the motion core runs on sys_clk and answers with core_stat_t.
`timescale 1ns/1ps

// Behaviour
// - Input asserted when pulled to ground
// - Output asserted turns transistor on
// - Reset held 20 ms clears all operation
// - Home strobe starts search on selected axes
// - Strobe starts selected axis from register in index and program modes
// - Shared inputs carry run, scan, speed, stop
// - Per axis busy/end output and fault output
// - Register number is binary, bit 0 lowest
// - Two mode inputs select four driving modes
module parallel_drive_start_port import pport_pkg::*; #(
	parameter int MS_CYCLES = CYC_PER_MS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire pin_in_t pins,
	input wire core_stat_t core,
	output oc_out_t oc,
	output core_cmd_t cmd
);
	localparam int MSW = $clog2(MS_CYCLES);

	// Every millisecond count must fit its counter; debounce and stop hold must be at least one tick
	if (MS_CYCLES < 2 || DEBOUNCE_MS < 1 || DEBOUNCE_MS >= (1 << DEB_W)
		|| RESET_HOLD_MS >= (1 << HOLD_W) || STOP_HOLD_MS < 1
		|| STOP_HOLD_MS >= (1 << HOLD_W) || END_PULSE_MS >= (1 << EP_W))
	begin : g_bad_param
		$error("parallel_drive_start_port: unsupported timing parameters");
	end

	localparam logic [DEB_W-1:0] DEB_LIM = DEB_W'(DEBOUNCE_MS);
	localparam logic [HOLD_W-1:0] RST_LIM = HOLD_W'(RESET_HOLD_MS);
	localparam logic [HOLD_W-1:0] STOP_LIM = HOLD_W'(STOP_HOLD_MS);
	localparam logic [EP_W-1:0] EP_LOAD = EP_W'(END_PULSE_MS);

	logic [NUM_IN-1:0] sync1_reg, sync2_reg;
	logic [MSW-1:0] ms_cnt_reg, ms_cnt_next;
	logic tick_reg, tick_next;
	logic [NUM_IN-1:0] filt_reg, filt_next, filt_d_reg;
	logic [DEB_W-1:0] deb_cnt_reg [NUM_IN];
	logic [DEB_W-1:0] deb_cnt_next [NUM_IN];
	logic [HOLD_W-1:0] reset_ms_reg, reset_ms_next, stop_ms_reg, stop_ms_next;
	logic stop_armed_reg, stop_armed_next;
	logic [EP_W-1:0] ep_ms_reg [2];
	logic [EP_W-1:0] ep_ms_next [2];
	core_cmd_t cmd_reg, cmd_next;
	oc_out_t oc_reg, oc_next;
	drive_mode_t mode;
	logic [REG_W-1:0] regv;
	logic [1:0] sel;
	logic [NUM_IN-1:0] rise;
	logic scan2, rst_hold, stop_fire;

	// Two-stage synchroniser; open pins idle high
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end

	// Millisecond enable and input qualification
	always_comb begin
		ms_cnt_next = ms_cnt_reg + MSW'(1);
		tick_next = 1'b0;
		if (ms_cnt_reg == MSW'(MS_CYCLES - 1)) begin
			ms_cnt_next = '0;
			tick_next = 1'b1;
		end
		for (int i = 0; i < NUM_IN; i++) begin
			filt_next[i] = filt_reg[i];
			deb_cnt_next[i] = deb_cnt_reg[i];
			if (tick_reg) begin
				// Pulled low means asserted
				if (!sync2_reg[i] == filt_reg[i]) begin
					deb_cnt_next[i] = '0;
				end else if (deb_cnt_reg[i] + DEB_W'(1) == DEB_LIM) begin
					filt_next[i] = !filt_reg[i];
					deb_cnt_next[i] = '0;
				end else begin
					deb_cnt_next[i] = deb_cnt_reg[i] + DEB_W'(1);
				end
			end
		end
	end

	// Decoded views of the qualified inputs
	assign mode = drive_mode_t'(filt_reg[IN_MODE_LO +: 2]);
	assign regv = filt_reg[IN_REG_LO +: REG_W];
	assign sel = {filt_reg[IN_YSEL], filt_reg[IN_XSEL]};
	assign rise = filt_reg & ~filt_d_reg;
	assign scan2 = (mode == MODE_SCAN) && regv[RB_SCAN];
	assign rst_hold = (reset_ms_reg == RST_LIM);
	assign stop_fire = tick_reg && stop_armed_reg && filt_reg[IN_REG_LO + RB_STOP]
		&& (stop_ms_reg == STOP_LIM - HOLD_W'(1)) && (mode != MODE_SCAN);

	// Hold counters for reset and stop
	always_comb begin
		reset_ms_next = reset_ms_reg;
		stop_ms_next = stop_ms_reg;
		stop_armed_next = stop_armed_reg;
		if (!filt_reg[IN_RESET]) begin
			reset_ms_next = '0;
		end else if (tick_reg && !rst_hold) begin
			reset_ms_next = reset_ms_reg + HOLD_W'(1);
		end
		// Stop shares the top register bit; arm only once strobe is released
		if (filt_reg[IN_STROBE] || rst_hold) begin
			stop_armed_next = 1'b0;
		end else if (!filt_reg[IN_REG_LO + RB_STOP]) begin
			stop_armed_next = 1'b1;
		end
		if (!filt_reg[IN_REG_LO + RB_STOP] || !stop_armed_reg) begin
			stop_ms_next = '0;
		end else if (tick_reg && stop_ms_reg != STOP_LIM) begin
			stop_ms_next = stop_ms_reg + HOLD_W'(1);
		end
	end

	// Command generation toward the motion core
	always_comb begin
		cmd_next = '0;
		cmd_next.start_reg = cmd_reg.start_reg;
		cmd_next.op_reset = rst_hold;
		if (!rst_hold) begin
			cmd_next.speed_sel = regv[RB_SPD_LO +: 2];
			// Home search ignored in scan mode 2
			if (rise[IN_HOME] && !scan2) begin
				cmd_next.home_start = sel;
			end
			// Strobe edge latches axes and register; caller set them up first
			if (rise[IN_STROBE] && (mode == MODE_INDEX || mode == MODE_PROG)) begin
				cmd_next.drive_start = sel;
				cmd_next.start_reg = regv;
			end
			if (scan2) begin
				cmd_next.jog_plus = {filt_reg[IN_XSEL], regv[RB_RUN_PLUS]};
				cmd_next.jog_minus = {filt_reg[IN_YSEL], regv[RB_RUN_MINUS]};
			end else if (mode == MODE_SCAN || mode == MODE_CONT) begin
				cmd_next.jog_plus = sel & {2{regv[RB_RUN_PLUS]}};
				cmd_next.jog_minus = sel & {2{regv[RB_RUN_MINUS]}};
			end
			if (stop_fire) begin
				cmd_next.stop = sel;
			end
		end
	end

	// Open-collector status outputs with optional end pulse
	always_comb begin
		for (int a = 0; a < 2; a++) begin
			ep_ms_next[a] = ep_ms_reg[a];
			if (rst_hold) begin
				ep_ms_next[a] = '0;
			end else if (core.axis_done[a]) begin
				ep_ms_next[a] = EP_LOAD;
			end else if (tick_reg && ep_ms_reg[a] != '0) begin
				ep_ms_next[a] = ep_ms_reg[a] - EP_W'(1);
			end
			// Conducting transistor shows an asserted output
			oc_next.busy_done_oe[a] = core.end_pulse_en ? (ep_ms_next[a] != '0)
				: (core.axis_busy[a] && !rst_hold);
			oc_next.fault_oe[a] = core.axis_fault[a];
		end
	end

	// State registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ms_cnt_reg <= '0;
			tick_reg <= 1'b0;
			filt_reg <= '0;
			filt_d_reg <= '0;
			for (int i = 0; i < NUM_IN; i++) begin
				deb_cnt_reg[i] <= '0;
			end
			reset_ms_reg <= '0;
			stop_ms_reg <= '0;
			stop_armed_reg <= 1'b0;
			ep_ms_reg[0] <= '0;
			ep_ms_reg[1] <= '0;
			cmd_reg <= '0;
			oc_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_cnt_next;
			tick_reg <= tick_next;
			filt_reg <= filt_next;
			filt_d_reg <= filt_reg;
			deb_cnt_reg <= deb_cnt_next;
			reset_ms_reg <= reset_ms_next;
			stop_ms_reg <= stop_ms_next;
			stop_armed_reg <= stop_armed_next;
			ep_ms_reg <= ep_ms_next;
			cmd_reg <= cmd_next;
			oc_reg <= oc_next;
		end
	end

	assign cmd = cmd_reg;
	assign oc = oc_reg;

	// Checks on the port behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_input_polarity: assert property ($rose(filt_reg[IN_HOME]) |-> !$past(sync2_reg[IN_HOME]))
		else $error("home qualified without a low pin");
	a_oc_busy_on: assert property (!core.end_pulse_en && core.axis_busy[0] && !rst_hold
		|=> oc.busy_done_oe[0])
		else $error("busy output not conducting");
	a_reset_hold: assert property ($rose(cmd.op_reset) |-> $past(reset_ms_reg, 2) == RST_LIM - HOLD_W'(1))
		else $error("operation reset before hold time");
	a_home_select: assert property (cmd.home_start != 2'h0 |-> cmd.home_start == $past(sel))
		else $error("home started on unselected axis");
	a_home_scan2: assert property (cmd.home_start != 2'h0 |-> !$past(scan2) && !$past(rst_hold))
		else $error("home started in scan mode 2");
	a_strobe_start: assert property (cmd.drive_start != 2'h0 |-> cmd.start_reg == $past(regv)
		&& ($past(mode) == MODE_INDEX || $past(mode) == MODE_PROG))
		else $error("drive start with wrong register or mode");
	a_stop_hold: assert property (cmd.stop != 2'h0 |-> $past(stop_ms_reg) == STOP_LIM - HOLD_W'(1))
		else $error("stop issued before hold time");
	a_jog_mode: assert property ((cmd.jog_plus | cmd.jog_minus) != 2'h0
		|-> $past(mode) == MODE_SCAN || $past(mode) == MODE_CONT)
		else $error("jog outside scan or continuous mode");
	a_end_pulse: assert property (core.end_pulse_en && core.axis_done[0] && !rst_hold
		|=> oc.busy_done_oe[0] [*2])
		else $error("end pulse missing");
	a_qualify_tick: assert property ($changed(filt_reg[IN_STROBE]) |-> $past(tick_reg))
		else $error("input qualified off the millisecond enable");
endmodule

// >>> src/pport_pkg.sv
// Constants, pin carriers and command carriers for the parallel drive start port.
// Assumes a single 50 MHz system clock and a motion core on that same clock.
package pport_pkg;
	// Clock and time base
	localparam int CLK_HZ = 50_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	// Times in milliseconds
	localparam int RESET_HOLD_MS = 20;
	localparam int STOP_HOLD_MS = 10;
	localparam int DEBOUNCE_MS = 2;
	localparam int END_PULSE_MS = 10;
	// Counter widths for millisecond counts
	localparam int DEB_W = 3;
	localparam int HOLD_W = 5;
	localparam int EP_W = 4;
	// Bit positions inside the synchronised input vector
	localparam int IN_RESET = 0;
	localparam int IN_HOME = 1;
	localparam int IN_STROBE = 2;
	localparam int IN_XSEL = 3;
	localparam int IN_YSEL = 4;
	localparam int IN_REG_LO = 5;
	localparam int IN_MODE_LO = 11;
	localparam int NUM_IN = 13;
	// Alternate functions of the register number bits
	localparam int RB_RUN_PLUS = 0;
	localparam int RB_RUN_MINUS = 1;
	localparam int RB_SPD_LO = 2;
	localparam int RB_SCAN = 4;
	localparam int RB_STOP = 5;
	localparam int REG_W = 6;

	typedef enum logic [1:0] {
		MODE_INDEX = 2'b00,
		MODE_SCAN = 2'b01,
		MODE_CONT = 2'b10,
		MODE_PROG = 2'b11
	} drive_mode_t;

	// Raw pins, low while pulled to interface ground; packs to the IN_* layout
	typedef struct packed {
		logic [1:0] drive_mode_sel_n;
		logic [5:0] reg_sel_n;
		logic y_sel_n;
		logic x_sel_n;
		logic strobe_n;
		logic home_n;
		logic reset_n;
	} pin_in_t;

	// Open-collector output enables, high while the transistor conducts
	typedef struct packed {
		logic [1:0] busy_done_oe;
		logic [1:0] fault_oe;
	} oc_out_t;

	// Status from the motion core, bit 0 is X, bit 1 is Y
	typedef struct packed {
		logic [1:0] axis_busy;
		logic [1:0] axis_done;
		logic [1:0] axis_fault;
		logic end_pulse_en;
	} core_stat_t;

	// Commands to the motion core, bit 0 is X, bit 1 is Y
	typedef struct packed {
		logic [1:0] home_start;
		logic [1:0] drive_start;
		logic [5:0] start_reg;
		logic [1:0] jog_plus;
		logic [1:0] jog_minus;
		logic [1:0] speed_sel;
		logic [1:0] stop;
		logic op_reset;
	} core_cmd_t;
endpackage

// >>> test/contact_model.sv
// Contact model: PLC contacts on the input pins, pull-ups on the outputs.
// Assumes the bench gives closed contacts as ones, in the pin_in_t layout.
`timescale 1ns/1ps
module contact_model import pport_pkg::*; (
	input wire pin_in_t closed,
	input wire oc_out_t oc,
	output pin_in_t pins,
	output logic [3:0] lvl
);
	// Closed contact pulls the pin to ground, an open pin floats high
	assign pins = pin_in_t'(~closed);
	// Pulled-up output line goes low while its transistor conducts
	assign lvl = ~{oc.busy_done_oe, oc.fault_oe};
endmodule

// >>> test/tb.sv
// Self-checking bench for the parallel drive start port.
// Assumes a shortened millisecond base of four clocks.
`timescale 1ns/1ps
module tb;
	import pport_pkg::*;
	localparam int MS = 4;
	logic sys_clk;
	logic nrst;
	pin_in_t sw;
	pin_in_t pins;
	core_stat_t st;
	oc_out_t oc;
	core_cmd_t cmd;
	logic [3:0] lvl;
	logic [7:0] got;
	int waited;
	int failures;
	int comparisons;

	parallel_drive_start_port #(.MS_CYCLES(MS)) i_parallel_drive_start_port (.sys_clk(sys_clk),
		.nrst(nrst), .pins(pins), .core(st), .oc(oc), .cmd(cmd));
	contact_model i_contact_model (.closed(sw), .oc(oc), .pins(pins), .lvl(lvl));

	// Clock generator
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic ms(input int n);
		repeat (n * MS) @(posedge sys_clk);
	endtask

	// Bounded wait for a one-cycle command pulse: 0 home, 1 drive, 2 stop
	task automatic catch_pulse(input int k, input int lim);
		got = 8'h00;
		for (waited = 0; waited < lim && got === 8'h00; waited++) begin
			@(posedge sys_clk);
			#1;
			got = {6'h00, k == 0 ? cmd.home_start : k == 1 ? cmd.drive_start : cmd.stop};
		end
	endtask

	task automatic t_home(input logic [1:0] sel);
		@(posedge sys_clk);
		sw.x_sel_n <= sel[0];
		sw.y_sel_n <= sel[1];
		ms(4);
		sw.home_n <= 1'b1;
		catch_pulse(0, 60);
		check("home_start", {6'h00, sel}, got);
		ms(11);
		sw.home_n <= 1'b0;
		ms(5);
		$display("home test done");
	endtask

	task automatic t_drive(input logic [1:0] mode, input logic [1:0] sel, input logic [5:0] r);
		logic ok;
		ok = (mode == 2'b00) || (mode == 2'b11);
		@(posedge sys_clk);
		sw.drive_mode_sel_n <= mode;
		sw.x_sel_n <= sel[0];
		sw.y_sel_n <= sel[1];
		sw.reg_sel_n <= r;
		ms(4);
		sw.strobe_n <= 1'b1;
		catch_pulse(1, 40);
		check("drive_start", ok ? {6'h00, sel} : 8'h00, got);
		if (ok) check("start_reg", {2'b00, r}, {2'b00, cmd.start_reg});
		ms(11);
		sw.strobe_n <= 1'b0;
		sw.reg_sel_n <= 6'h00;
		ms(5);
		$display("drive test done");
	endtask

	task automatic t_jog(input logic [1:0] mode, input logic [5:0] r, input logic [5:0] exp);
		@(posedge sys_clk);
		sw.drive_mode_sel_n <= mode;
		sw.x_sel_n <= 1'b1;
		sw.y_sel_n <= 1'b0;
		sw.reg_sel_n <= r;
		ms(5);
		#1;
		check("jog speed", {2'b00, exp}, {2'b00, cmd.jog_plus, cmd.jog_minus, cmd.speed_sel});
		$display("jog test done");
	endtask

	task automatic t_stop();
		@(posedge sys_clk);
		sw.drive_mode_sel_n <= 2'b00;
		sw.reg_sel_n <= 6'h00;
		ms(5);
		sw.reg_sel_n[5] <= 1'b1;
		catch_pulse(2, 100);
		check("stop", 8'h01, got);
		check("stop held long", 8'h01, {7'h00, waited >= 10 * MS});
		@(posedge sys_clk);
		sw.reg_sel_n <= 6'h00;
		ms(5);
		$display("stop test done");
	endtask

	task automatic t_status();
		@(posedge sys_clk);
		st.axis_busy <= 2'b01;
		st.axis_fault <= 2'b10;
		repeat (3) @(posedge sys_clk);
		#1;
		check("line levels", 8'h09, {4'h0, lvl});
		@(posedge sys_clk);
		st.axis_busy <= 2'b00;
		st.axis_fault <= 2'b00;
		st.end_pulse_en <= 1'b1;
		st.axis_done <= 2'b01;
		@(posedge sys_clk);
		st.axis_done <= 2'b00;
		repeat (30) @(posedge sys_clk);
		#1;
		check("end pulse on", 8'h01, {6'h00, oc.busy_done_oe});
		repeat (15) @(posedge sys_clk);
		#1;
		check("end pulse off", 8'h00, {6'h00, oc.busy_done_oe});
		@(posedge sys_clk);
		st.end_pulse_en <= 1'b0;
		$display("status test done");
	endtask

	task automatic t_pin_reset();
		t_jog(2'b10, 6'h01, 6'b01_00_00);
		@(posedge sys_clk);
		sw.reset_n <= 1'b1;
		ms(27);
		#1;
		check("op_reset on", 8'h01, {7'h00, cmd.op_reset});
		check("jog cleared", 8'h00, {6'h00, cmd.jog_plus});
		@(posedge sys_clk);
		sw.reset_n <= 1'b0;
		ms(5);
		#1;
		check("op_reset off", 8'h00, {7'h00, cmd.op_reset});
		$display("pin reset test done");
	endtask

	task automatic close_out();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Watchdog against a hang; the tests need about 1,000 clocks
	initial begin
		#200000;
		failures++;
		close_out();
	end

	// Main sequence
	initial begin
		sw = '0;
		st = '0;
		nrst = 1'b0;
		failures = 0;
		comparisons = 0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		#1;
		check("outputs after reset", 8'h00, {4'h0, oc});
		check("pulses after reset", 8'h00, {2'b00, cmd.home_start, cmd.drive_start, cmd.stop});
		t_home(2'b11);
		t_home(2'b01);
		t_drive(2'b00, 2'b10, 6'h2A);
		t_drive(2'b01, 2'b01, 6'h15);
		t_drive(2'b10, 2'b01, 6'h0F);
		t_drive(2'b11, 2'b11, 6'h35);
		t_jog(2'b10, 6'h09, 6'b01_00_10);
		t_jog(2'b01, 6'h12, 6'b10_01_00);
		t_jog(2'b01, 6'h06, 6'b00_01_01);
		t_stop();
		t_status();
		t_pin_reset();
		close_out();
	end
endmodule
